/* File: rtl/qbm_pkg.sv */
// Shared constants of the quad bused MII port
package qbm_pkg;
  localparam int unsigned NCH = 4;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  // Control register fields
  localparam int unsigned CTRL_SMART = 0;
  localparam int unsigned CTRL_SERIAL = 1;
  localparam int unsigned CTRL_SPEED_LSB = 4;
  localparam int unsigned CTRL_FDX_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_00F0;
  // Status register fields
  localparam int unsigned STAT_COLS_LSB = 0;
  localparam int unsigned STAT_COLF_LSB = 4;
  localparam int unsigned STAT_TXEN_LSB = 8;
  localparam int unsigned STAT_FOE = 12;
  localparam int unsigned STAT_SOE = 13;
  // Receive error kinds and their nibble codes
  localparam logic [1:0] ERRK_PACKET = 2'h0;
  localparam logic [1:0] ERRK_LINK = 2'h1;
  localparam logic [1:0] ERRK_PREMAT = 2'h2;
  localparam logic [3:0] ERRC_PACKET = 4'h2;
  localparam logic [3:0] ERRC_LINK = 4'h3;
  localparam logic [3:0] ERRC_PREMAT = 4'h4;
  localparam logic [3:0] ERRC_CODE = 4'h5;
  // Transmit symbols
  localparam logic [4:0] SYM_TXERR = 5'h04;
  localparam logic [4:0] SYM_BLANK_A = 5'h15;
  localparam logic [4:0] SYM_BLANK_B = 5'h0A;
  localparam logic [4:0] SYM_IDLE = 5'h1F;
endpackage : qbm_pkg

/* File: rtl/qbm_tx_lane.sv */
// One channel transmit path: enable select, blanking and symbol encode
`timescale 1ns/1ps
`default_nettype none
module qbm_tx_lane (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Mode of this channel
  input  wire logic       smart,
  input  wire logic       speed100,
  // Synchronised shared transmit pins
  input  wire logic       valid_slow,
  input  wire logic       valid_fast,
  input  wire logic       txd_slow,
  input  wire logic [3:0] txd_fast,
  input  wire logic       tx_er,
  input  wire logic       rise_slow,
  input  wire logic       rise_fast,
  // To the channel core
  output logic            tx_en,
  output logic            tx_bit,
  output logic [4:0]      tx_sym
);
  logic       tx_en_ff, nxt_tx_en;
  logic       tx_bit_ff, nxt_tx_bit;
  logic [4:0] tx_sym_ff, nxt_tx_sym;
  logic       phase_ff, nxt_phase;
  logic       en, blank;

  // Data code groups of the nibble encoder
  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h00;
    case (n)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
      default: s = 5'h00;
    endcase
    return s;
  endfunction : enc4b5b

  // Which valid pin enables this lane, and whether it is blanked
  always_comb begin
    if (smart) begin
      en = valid_fast;
    end else if (speed100) begin
      en = valid_fast;
    end else begin
      en = valid_slow;
    end
    blank = smart & valid_slow;
  end

  // Capture on the sampled transmit clock edge of the channel speed
  always_comb begin
    nxt_tx_en = tx_en_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sym = tx_sym_ff;
    nxt_phase = phase_ff;
    if (!speed100 && rise_slow) begin
      nxt_tx_en = en;
      nxt_tx_bit = blank ? 1'b1 : (en & txd_slow);
    end
    if (speed100 && rise_fast) begin
      nxt_tx_en = en;
      if (blank) begin
        // Phase flips so the line pattern stays 1,0,1,0 across symbols
        nxt_tx_sym = phase_ff ? qbm_pkg::SYM_BLANK_B
                              : qbm_pkg::SYM_BLANK_A;
        nxt_phase = ~phase_ff;
      end else if (en && tx_er) begin
        nxt_tx_sym = qbm_pkg::SYM_TXERR;
      end else if (en) begin
        nxt_tx_sym = enc4b5b(txd_fast);
      end else begin
        nxt_tx_sym = qbm_pkg::SYM_IDLE;
        nxt_phase = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_ff <= 1'b0;
      tx_bit_ff <= 1'b0;
      tx_sym_ff <= qbm_pkg::SYM_IDLE;
      phase_ff <= 1'b0;
    end else begin
      tx_en_ff <= nxt_tx_en;
      tx_bit_ff <= nxt_tx_bit;
      tx_sym_ff <= nxt_tx_sym;
      phase_ff <= nxt_phase;
    end
  end

  assign tx_en = tx_en_ff;
  assign tx_bit = tx_bit_ff;
  assign tx_sym = tx_sym_ff;
endmodule : qbm_tx_lane
`default_nettype wire

/* File: rtl/qbm_port.sv */
// Bused MII port of a four-channel transceiver with an APB control slave
`timescale 1ns/1ps
`default_nettype none
module qbm_port (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive grants from the controller
  input  wire logic [3:0]  rx_bus_grant_fast,
  input  wire logic [3:0]  rx_bus_grant_slow,
  // Shared transmit pins from the controller
  input  wire logic [3:0]  tx_valid_slow,
  input  wire logic [3:0]  tx_valid_fast,
  input  wire logic        txd_slow,
  input  wire logic [3:0]  txd_fast,
  input  wire logic        tx_er,
  input  wire logic        tx_clock_slow,
  input  wire logic        tx_clock_fast,
  // Per-channel receive state from the channel cores
  input  wire logic [15:0] ch_rxd,
  input  wire logic [3:0]  ch_rx_dv,
  input  wire logic [3:0]  ch_rx_er,
  input  wire logic [7:0]  ch_err_kind,
  input  wire logic [3:0]  ch_rx_clk,
  input  wire logic [3:0]  ch_rxd_serial,
  input  wire logic [3:0]  ch_rx_active,
  input  wire logic [3:0]  ch_jabber,
  // Shared fast receive bus
  output logic [3:0]       rxd_fast,
  output logic             rx_dv,
  output logic             rx_er,
  output logic             rx_clock_fast,
  output logic             rx_fast_oe,
  // Shared slow receive bus
  output logic             rxd_slow,
  output logic             rx_clock_slow,
  output logic             rx_slow_oe,
  // Collisions
  output logic [3:0]       col_slow,
  output logic [3:0]       col_fast,
  // To the channel cores
  output logic [3:0]       ch_tx_en,
  output logic [3:0]       ch_tx_bit,
  output logic [19:0]      ch_tx_sym
);
  localparam int unsigned PW = 24;

  // Pin synchronisers: first stage is read only by the second
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] s1_ff, s2_ff;
  logic [1:0]    clk_prev_ff;
  logic [3:0]    g_fast, g_slow, v_slow, v_fast, txd_f;
  logic          txd_s, ter, clk_s, clk_f, rise_s, rise_f;

  assign pin_raw = {rx_bus_grant_fast, rx_bus_grant_slow, tx_valid_slow,
                    tx_valid_fast, txd_fast, txd_slow, tx_er,
                    tx_clock_slow, tx_clock_fast};
  assign {g_fast, g_slow, v_slow, v_fast, txd_f, txd_s, ter, clk_s, clk_f}
    = s2_ff;
  assign rise_s = clk_s & ~clk_prev_ff[1];
  assign rise_f = clk_f & ~clk_prev_ff[0];

  // Two-flop sampling of everything from the controller side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      clk_prev_ff <= 2'h0;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      clk_prev_ff <= {clk_s, clk_f};
    end
  end

  // Control register and APB answer state
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [31:0] stat_word;
  logic        smart, serial_sel;
  logic [3:0]  spd100, fdx;
  logic        hit_ctrl, hit_stat;

  assign smart = ctrl_ff[qbm_pkg::CTRL_SMART];
  assign serial_sel = ctrl_ff[qbm_pkg::CTRL_SERIAL];
  assign spd100 = ctrl_ff[qbm_pkg::CTRL_SPEED_LSB +: 4];
  assign fdx = ctrl_ff[qbm_pkg::CTRL_FDX_LSB +: 4];
  assign hit_ctrl = (paddr == qbm_pkg::ADDR_CTRL);
  assign hit_stat = (paddr == qbm_pkg::ADDR_STAT);

  // Setup cycle loads the answer, so every access completes with no wait state
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel && !penable) begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~(hit_ctrl | (hit_stat & ~pwrite));
      if (!pwrite && hit_ctrl) begin
        nxt_prdata = ctrl_ff;
      end else if (!pwrite && hit_stat) begin
        nxt_prdata = stat_word;
      end else begin
        nxt_prdata = 32'h0000_0000;
      end
    end
    if (psel && penable && pready_ff && pwrite && hit_ctrl) begin
      nxt_ctrl = {20'h0_0000, pwdata[11:4], 2'h0, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= qbm_pkg::CTRL_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // Transmit lanes, one per channel
  logic [3:0] lane_en;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      qbm_tx_lane u_lane (
        .pclk       (pclk),
        .presetn    (presetn),
        .smart      (smart),
        .speed100   (spd100[gi]),
        .valid_slow (v_slow[gi]),
        .valid_fast (v_fast[gi]),
        .txd_slow   (txd_s),
        .txd_fast   (txd_f),
        .tx_er      (ter),
        .rise_slow  (rise_s),
        .rise_fast  (rise_f),
        .tx_en      (lane_en[gi]),
        .tx_bit     (ch_tx_bit[gi]),
        .tx_sym     (ch_tx_sym[gi*5 +: 5])
      );
    end
  endgenerate
  assign ch_tx_en = lane_en;

  // Receive bus selection state
  logic [3:0] rxd_f_ff, nxt_rxd_f;
  logic       dv_ff, nxt_dv, er_ff, nxt_er, rck_f_ff, nxt_rck_f;
  logic       foe_ff, nxt_foe;
  logic       rxd_s_ff, nxt_rxd_s, rck_s_ff, nxt_rck_s, soe_ff, nxt_soe;
  logic [3:0] fast_sel, slow_sel;

  // Effective grants per bus; only one is expected high at a time
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (smart) begin
        fast_sel[i] = g_fast[i] & spd100[i];
        slow_sel[i] = g_fast[i] & ~spd100[i];
      end else begin
        fast_sel[i] = g_fast[i] & spd100[i];
        slow_sel[i] = g_slow[i] & ~spd100[i];
      end
    end
  end

  // Mux the granted channel; lowest index wins if the controller errs
  always_comb begin
    nxt_rxd_f = 4'h0;
    nxt_dv = 1'b0;
    nxt_er = 1'b0;
    nxt_rck_f = 1'b0;
    nxt_foe = 1'b0;
    nxt_rxd_s = 1'b0;
    nxt_rck_s = 1'b0;
    nxt_soe = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (fast_sel[i]) begin
        nxt_foe = 1'b1;
        nxt_rck_f = ch_rx_clk[i];
        nxt_dv = ch_rx_dv[i];
        nxt_er = ch_rx_er[i];
        nxt_rxd_f = ch_rxd[i*4 +: 4];
        if (ch_rx_er[i]) begin
          case (ch_err_kind[i*2 +: 2])
            qbm_pkg::ERRK_PACKET: nxt_rxd_f = qbm_pkg::ERRC_PACKET;
            qbm_pkg::ERRK_LINK:   nxt_rxd_f = qbm_pkg::ERRC_LINK;
            qbm_pkg::ERRK_PREMAT: nxt_rxd_f = qbm_pkg::ERRC_PREMAT;
            default:              nxt_rxd_f = qbm_pkg::ERRC_CODE;
          endcase
        end
      end
      if (slow_sel[i]) begin
        // Slow bus carries no valid or error signal
        nxt_soe = 1'b1;
        nxt_rck_s = ch_rx_clk[i];
        nxt_rxd_s = ch_rxd_serial[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_f_ff <= 4'h0;
      dv_ff <= 1'b0;
      er_ff <= 1'b0;
      rck_f_ff <= 1'b0;
      foe_ff <= 1'b0;
      rxd_s_ff <= 1'b0;
      rck_s_ff <= 1'b0;
      soe_ff <= 1'b0;
    end else begin
      rxd_f_ff <= nxt_rxd_f;
      dv_ff <= nxt_dv;
      er_ff <= nxt_er;
      rck_f_ff <= nxt_rck_f;
      foe_ff <= nxt_foe;
      rxd_s_ff <= nxt_rxd_s;
      rck_s_ff <= nxt_rck_s;
      soe_ff <= nxt_soe;
    end
  end

  assign rxd_fast = rxd_f_ff;
  assign rx_dv = dv_ff;
  assign rx_er = er_ff;
  assign rx_clock_fast = rck_f_ff;
  assign rx_fast_oe = foe_ff;
  assign rxd_slow = rxd_s_ff;
  assign rx_clock_slow = rck_s_ff;
  assign rx_slow_oe = soe_ff;

  // Collision outputs; registered, so one cycle behind the true AND
  logic [3:0] cols_ff, nxt_cols, colf_ff, nxt_colf;
  logic [3:0] raw_s, raw_f;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      raw_s[i] = ~fdx[i] & ~spd100[i]
               & lane_en[i] & ch_rx_active[i];
      if (serial_sel && !spd100[i]) begin
        raw_s[i] = ch_jabber[i];
      end
      raw_f[i] = ~fdx[i] & spd100[i]
               & lane_en[i] & ch_rx_active[i];
    end
    nxt_cols = raw_s;
    nxt_colf = smart ? (raw_f | raw_s) : raw_f;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cols_ff <= 4'h0;
      colf_ff <= 4'h0;
    end else begin
      cols_ff <= nxt_cols;
      colf_ff <= nxt_colf;
    end
  end

  assign col_slow = cols_ff;
  assign col_fast = colf_ff;

  // Status word shows live collision, enable and bus drive state
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[qbm_pkg::STAT_COLS_LSB +: 4] = cols_ff;
    stat_word[qbm_pkg::STAT_COLF_LSB +: 4] = colf_ff;
    stat_word[qbm_pkg::STAT_TXEN_LSB +: 4] = lane_en;
    stat_word[qbm_pkg::STAT_FOE] = foe_ff;
    stat_word[qbm_pkg::STAT_SOE] = soe_ff;
  end
endmodule : qbm_port
`default_nettype wire

/* File: tb/qbm_port_assertions.sv */
// Checker of the bused port: rx bus steering, collisions and APB handshake
`timescale 1ns/1ps
`default_nettype none
module qbm_port_assertions (
  // Clock, reset and APB answer
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Grants and channel state
  input wire logic [3:0] rx_bus_grant_fast,
  input wire logic [3:0] rx_bus_grant_slow,
  input wire logic [3:0] ch_rx_active,
  input wire logic [3:0] ch_jabber,
  // Shared rx buses and collisions
  input wire logic [3:0] rxd_fast,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic       rx_clock_fast,
  input wire logic       rx_fast_oe,
  input wire logic       rxd_slow,
  input wire logic       rx_clock_slow,
  input wire logic       rx_slow_oe,
  input wire logic [3:0] col_slow,
  input wire logic [3:0] col_fast
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Grant pins cross two flops and a steering stage, hence three edges
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_no_grant;
    (rx_bus_grant_fast == 4'h0) [*4];
  endsequence
  sequence s_lone_grant;
    $onehot0(rx_bus_grant_fast | rx_bus_grant_slow) [*4];
  endsequence

  a_setup_ready: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_float: assert property (s_no_grant |-> !rx_fast_oe)
    else $error("fast bus driven with no grant");
  a_fast_cause: assert property (
    rx_fast_oe |-> $past(rx_bus_grant_fast, 3) != 4'h0)
    else $error("fast bus driven without earlier grant");
  a_slow_cause: assert property (
    rx_slow_oe |-> ($past(rx_bus_grant_fast, 3) |
                    $past(rx_bus_grant_slow, 3)) != 4'h0)
    else $error("slow bus driven without earlier grant");
  a_float_zero: assert property (
    !rx_fast_oe |-> {rxd_fast, rx_dv, rx_er, rx_clock_fast} == 7'h00)
    else $error("fast bus data while released");
  a_slow_zero: assert property (
    !rx_slow_oe |-> !rxd_slow && !rx_clock_slow)
    else $error("slow bus data while released");
  a_one_bus: assert property (
    s_lone_grant |-> !(rx_fast_oe && rx_slow_oe))
    else $error("both buses driven for one grant");
  a_err_code: assert property (
    rx_er |-> rxd_fast inside {4'h2, 4'h3, 4'h4, 4'h5})
    else $error("rx error without error code");
  // Both collision sources are formed in the same cycle, one stage deep
  a_col_fast: assert property (
    (col_fast & ~$past(ch_rx_active | ch_jabber)) == 4'h0)
    else $error("fast collision without rx activity");
  a_col_slow: assert property (
    (col_slow & ~$past(ch_rx_active | ch_jabber)) == 4'h0)
    else $error("slow collision without rx activity");
endmodule : qbm_port_assertions
`default_nettype wire

/* File: tb/qbm_mac_model.sv */
// Controller model: drives shared transmit pins and the link clocks
`timescale 1ns/1ps
`default_nettype none
module qbm_mac_model (
  // Clock of the block; every pin change is launched on its rising edge
  input  wire logic  pclk,
  // Link clocks
  output logic       tx_clock_slow,
  output logic       tx_clock_fast,
  // Shared transmit pins
  output logic [3:0] tx_valid_slow,
  output logic [3:0] tx_valid_fast,
  output logic       txd_slow,
  output logic [3:0] txd_fast,
  output logic       tx_er
);
  // Clocks rest low outside frames
  initial begin
    tx_clock_slow = 1'b0;
    tx_clock_fast = 1'b0;
    tx_valid_slow = 4'h0;
    tx_valid_fast = 4'h0;
    txd_slow = 1'b0;
    txd_fast = 4'h0;
    tx_er = 1'b0;
  end

  // One 200 ns beat: one serial bit and one nibble per rise
  // Low for 3 edges, high for 5: the rise comes early so lane and collision
  // outputs have both settled when the beat returns
  task automatic beat(input logic [3:0] vs, input logic [3:0] vf,
                      input logic ds, input logic [3:0] df, input logic er);
    @(posedge pclk);
    tx_clock_slow <= 1'b0;
    tx_clock_fast <= 1'b0;
    tx_valid_slow <= vs;
    tx_valid_fast <= vf;
    txd_slow <= ds;
    txd_fast <= df;
    tx_er <= er;
    repeat (3) @(posedge pclk);
    tx_clock_slow <= 1'b1;
    tx_clock_fast <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
  endtask : beat

  // End of frame: clocks stop, stale data is not left standing
  task automatic idle();
    @(posedge pclk);
    tx_clock_slow <= 1'b0;
    tx_clock_fast <= 1'b0;
    tx_valid_slow <= 4'h0;
    tx_valid_fast <= 4'h0;
    txd_slow <= ~txd_slow;
    txd_fast <= ~txd_fast;
    tx_er <= 1'b0;
  endtask : idle
endmodule : qbm_mac_model
`default_nettype wire

/* File: tb/qbm_port_tb.sv */
// Testbench of the quad bused port: rx steering, tx lanes, collisions, APB
`timescale 1ns/1ps
`default_nettype none
module qbm_port_tb;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [3:0]  gf, gs;
    logic        er;
    logic [1:0]  ch;
    logic        foe, soe;
  } qbm_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        tx_clock_slow, tx_clock_fast, txd_slow, tx_er, rx_dv, rx_er;
  logic        rx_clock_fast, rx_fast_oe, rxd_slow, rx_clock_slow, rx_slow_oe;
  logic [7:0]  paddr, ch_err_kind;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  rx_bus_grant_fast, rx_bus_grant_slow, tx_valid_slow;
  logic [3:0]  tx_valid_fast, txd_fast, ch_rx_dv, ch_rx_er, ch_rx_clk;
  logic [3:0]  ch_rxd_serial, ch_rx_active, ch_jabber, rxd_fast;
  logic [3:0]  col_slow, col_fast, ch_tx_en, ch_tx_bit;
  logic [15:0] ch_rxd;
  logic [19:0] ch_tx_sym;
  logic [4:0]  sy;
  logic [4:0]  enc [16];
  qbm_row_t    rows [11];
  qbm_row_t    r;
  int          errors, cmp_count, k;

  qbm_port qbm_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_bus_grant_fast,
    .rx_bus_grant_slow, .tx_valid_slow, .tx_valid_fast, .txd_slow, .txd_fast,
    .tx_er, .tx_clock_slow, .tx_clock_fast, .ch_rxd, .ch_rx_dv, .ch_rx_er,
    .ch_err_kind, .ch_rx_clk, .ch_rxd_serial, .ch_rx_active, .ch_jabber,
    .rxd_fast, .rx_dv, .rx_er, .rx_clock_fast, .rx_fast_oe, .rxd_slow,
    .rx_clock_slow, .rx_slow_oe, .col_slow, .col_fast, .ch_tx_en,
    .ch_tx_bit, .ch_tx_sym);
  qbm_mac_model qbm_mac_model_i (.pclk, .tx_clock_slow, .tx_clock_fast,
    .tx_valid_slow, .tx_valid_fast, .txd_slow, .txd_fast, .tx_er);

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; read data and error land in rd and se
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Hang guard, far beyond the expected run of some 9 us
  initial begin
    #200000;
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_bus_grant_fast, rx_bus_grant_slow, ch_rx_er} = '0;
    {ch_rx_active, ch_jabber, errors, cmp_count} = '0;
    ch_rxd = 16'hECA9;
    ch_rx_dv = 4'hB;
    ch_err_kind = 8'hE4;
    ch_rx_clk = 4'hA;
    ch_rxd_serial = 4'h6;
    enc = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    rows = '{'{12'h0F0, 4'h2, 4'h0, 1'h0, 2'h1, 1'h1, 1'h0},
             '{12'h0F0, 4'h0, 4'h0, 1'h0, 2'h1, 1'h0, 1'h0},
             '{12'h0D0, 4'h2, 4'h0, 1'h0, 2'h1, 1'h0, 1'h0},
             '{12'h0D0, 4'h0, 4'h2, 1'h0, 2'h1, 1'h0, 1'h1},
             '{12'h0D1, 4'h0, 4'h2, 1'h0, 2'h1, 1'h0, 1'h0},
             '{12'h0D1, 4'h2, 4'h0, 1'h0, 2'h1, 1'h0, 1'h1},
             '{12'h0F1, 4'h4, 4'h0, 1'h1, 2'h2, 1'h1, 1'h0},
             '{12'h0F0, 4'h8, 4'h0, 1'h1, 2'h3, 1'h1, 1'h0},
             '{12'h0F0, 4'h1, 4'h0, 1'h1, 2'h0, 1'h1, 1'h0},
             '{12'h0F0, 4'h2, 4'h0, 1'h1, 2'h1, 1'h1, 1'h0},
             '{12'h0F0, 4'h4, 4'h0, 1'h0, 2'h2, 1'h1, 1'h0}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    // Reset values, field mask, refused accesses
    check("sym_rst", ch_tx_sym, {4{qbm_pkg::SYM_IDLE}});
    check("oe_rst", {rx_slow_oe, rx_fast_oe, col_fast, col_slow}, 32'h0);
    apb(1'b0, qbm_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rst", rd, qbm_pkg::CTRL_RESET);
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, qbm_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rw", rd, 32'h0000_0FF3);
    apb(1'b1, 8'h08, 32'h1);
    check("unmapped", {rd[30:0], se}, 32'h1);
    apb(1'b1, qbm_pkg::ADDR_STAT, 32'h1);
    check("stat_ro", se, 32'h1);
    $display("test reset and registers done");
    // Rx steering rows; the controller grants one channel at a time
    for (k = 0; k < 11; k++) begin
      r = rows[k];
      apb(1'b1, qbm_pkg::ADDR_CTRL, {20'h0, r.ctrl});
      rx_bus_grant_fast <= r.gf;
      rx_bus_grant_slow <= r.gs;
      ch_rx_er <= {4{r.er}};
      repeat (4) @(posedge pclk);
      #1;
      check("fast_oe", rx_fast_oe, r.foe);
      check("slow_oe", rx_slow_oe, r.soe);
      check("rxd_fast", rxd_fast, r.foe ? (r.er ? 4'h2 + r.ch :
            ch_rxd[4*r.ch +: 4]) : 4'h0);
      check("rx_dv", rx_dv, r.foe & ch_rx_dv[r.ch]);
      check("rx_er", rx_er, r.foe & r.er);
      check("rx_clk", {rx_clock_slow, rx_clock_fast},
            {r.soe & ch_rx_clk[r.ch], r.foe & ch_rx_clk[r.ch]});
      check("rxd_slow", rxd_slow, r.soe & ch_rxd_serial[r.ch]);
      apb(1'b0, qbm_pkg::ADDR_STAT, 32'h0);
      check("stat_oe", rd[13:12], {r.soe, r.foe});
    end
    rx_bus_grant_fast <= 4'h0;
    $display("test rx table done");
    // Fast lane: every nibble coded, error symbol, slow valid ignored
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'h0F0);
    ch_rx_active <= 4'hF;
    for (k = 0; k < 16; k++) begin
      qbm_mac_model_i.beat(4'h0, 4'h1, 1'b0, k[3:0], 1'b0);
      check("sym", ch_tx_sym[4:0], enc[k]);
    end
    check("col_fast", col_fast[0], 1'b1);
    // Full duplex on channel 0 must silence its collision output
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'h1F0);
    repeat (2) @(posedge pclk);
    #1;
    check("col_fdx", col_fast[0], 1'b0);
    qbm_mac_model_i.beat(4'h0, 4'h1, 1'b0, 4'h0, 1'b1);
    check("sym_err", ch_tx_sym[4:0], qbm_pkg::SYM_TXERR);
    qbm_mac_model_i.beat(4'h1, 4'h0, 1'b1, 4'h0, 1'b0);
    check("en_slow100", ch_tx_en[0], 1'b0);
    qbm_mac_model_i.idle();
    // Slow lane: fast valid ignored, serial bits pass, error has no effect
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'h0E0);
    qbm_mac_model_i.beat(4'h0, 4'h1, 1'b1, 4'h0, 1'b0);
    check("en_fast10", ch_tx_en[0], 1'b0);
    qbm_mac_model_i.beat(4'h1, 4'h0, 1'b1, 4'h0, 1'b1);
    check("bit_er", {ch_tx_en[0], ch_tx_bit[0]}, 2'h3);
    check("col_slow", col_slow[0], 1'b1);
    qbm_mac_model_i.beat(4'h1, 4'h0, 1'b0, 4'h0, 1'b0);
    check("bit0", ch_tx_bit[0], 1'b0);
    qbm_mac_model_i.idle();
    // Smart mode: fast valid drives both lanes, blanking after the preamble
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'h0E1);
    qbm_mac_model_i.beat(4'h0, 4'h3, 1'b1, 4'h6, 1'b0);
    check("smart_en", ch_tx_en[1:0], 2'h3);
    check("smart_bit", ch_tx_bit[0], 1'b1);
    check("smart_sym", ch_tx_sym[9:5], enc[6]);
    check("smart_col", col_fast[0], 1'b1);
    qbm_mac_model_i.beat(4'h3, 4'h3, 1'b0, 4'h6, 1'b0);
    sy = ch_tx_sym[9:5];
    check("blank_bit", ch_tx_bit[0], 1'b1);
    check("blank_sym", sy inside {qbm_pkg::SYM_BLANK_A,
          qbm_pkg::SYM_BLANK_B}, 1'b1);
    qbm_mac_model_i.beat(4'h3, 4'h3, 1'b0, 4'h6, 1'b0);
    check("blank_alt", ch_tx_sym[9:5], sy ^ 5'h1F);
    qbm_mac_model_i.beat(4'h0, 4'h0, 1'b0, 4'h0, 1'b0);
    check("tx_end", {ch_tx_en, ch_tx_sym[9:5]}, {4'h0, qbm_pkg::SYM_IDLE});
    qbm_mac_model_i.idle();
    $display("test tx lanes done");
    // Serial select on a 10 Mbit/s channel shows jabber on collision
    apb(1'b1, qbm_pkg::ADDR_CTRL, 32'h0E2);
    ch_rx_active <= 4'h0;
    ch_jabber <= 4'h1;
    repeat (4) @(posedge pclk);
    #1;
    check("jabber_on", col_slow[0], 1'b1);
    ch_jabber <= 4'h0;
    repeat (4) @(posedge pclk);
    #1;
    check("jabber_off", col_slow[0], 1'b0);
    $display("test jabber done");
    test_done();
  end
endmodule : qbm_port_tb

bind qbm_port qbm_port_assertions qbm_port_assertions_i (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .rx_bus_grant_fast, .rx_bus_grant_slow,
  .ch_rx_active, .ch_jabber, .rxd_fast, .rx_dv, .rx_er, .rx_clock_fast,
  .rx_fast_oe, .rxd_slow, .rx_clock_slow, .rx_slow_oe, .col_slow, .col_fast);
`default_nettype wire
